// *** design/can_mbx_regs.sv ***
// Mailbox length code, payload and acceptance filter configuration registers behind APB.
//
// Local design decisions: the placing of the registers and the APB slave port.
module can_mbx_regs (
	input wire logic CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [1:0] TX_MAILBOX_EMPTY,
	input wire logic INIT_MODE,
	input wire logic RX_WR,
	input wire logic [3:0] RX_SLOT,
	input wire logic [7:0] RX_DATA,
	output logic [5:0] FILTER_ACTIVE,
	output logic [11:0] FILTER_SCALE,
	output logic [5:0] FILTER_MODE_HIGH,
	output logic [5:0] FILTER_MODE_LOW,
	output logic [383:0] FILTER_BYTES,
	output logic [7:0] TX_LENGTH,
	output logic [127:0] TX_PAYLOAD
);
	// Whole register state of the block, held in one record.
	typedef struct packed {
		logic [can_mbx_pkg::NUM_PAIRS-1:0][7:0] cfg;
		logic [7:0] mode0;
		logic [3:0] mode1;
		logic [can_mbx_pkg::NUM_TX-1:0][7:0] tx_len;
		can_mbx_pkg::bytes8_t [can_mbx_pkg::NUM_TX-1:0] tx_pay;
		logic [7:0] rx_len;
		can_mbx_pkg::bytes8_t rx_pay;
		can_mbx_pkg::bytes8_t [can_mbx_pkg::NUM_FILTERS-1:0] fbytes;
		logic [31:0] rdata;
		logic err;
	} state_t;

	state_t s_r;
	state_t s_nxt;
	logic setup;
	logic wr_take;
	can_mbx_pkg::region_t region;
	logic [2:0] sel_a;
	logic [3:0] sel_b;
	logic [7:0] rd_byte;
	logic rd_ok;
	logic [11:0] mode_all;
	logic [7:0] wbyte;

	// Activate bit of a filter from the configuration pair that holds it.
	function automatic logic act_of(input logic [can_mbx_pkg::NUM_PAIRS-1:0][7:0] cfg, input int f);
		logic [7:0] pair;
		pair = cfg[f / 2];
		if (f % 2 == 1) begin
			act_of = pair[can_mbx_pkg::CFG_ACT_HI];
		end else begin
			act_of = pair[can_mbx_pkg::CFG_ACT_LO];
		end
	endfunction

	// Scale field of a filter, picked the same way.
	function automatic logic [1:0] scale_of(input logic [can_mbx_pkg::NUM_PAIRS-1:0][7:0] cfg, input int f);
		logic [7:0] pair;
		pair = cfg[f / 2];
		if (f % 2 == 1) begin
			scale_of = pair[can_mbx_pkg::CFG_SCALE_HI +: can_mbx_pkg::SCALE_W];
		end else begin
			scale_of = pair[can_mbx_pkg::CFG_SCALE_LO +: can_mbx_pkg::SCALE_W];
		end
	endfunction

	apb_decode u_dec (
		.psel(PSEL),
		.penable(PENABLE),
		.pwrite(PWRITE),
		.paddr(PADDR),
		.setup(setup),
		.wr_take(wr_take),
		.pready(PREADY),
		.region(region),
		.sel_a(sel_a),
		.sel_b(sel_b)
	);

	// Only the low byte of the bus carries register data.
	assign wbyte = PWDATA[7:0];

	// Both mode registers seen as one twelve-bit vector, two bits per filter.
	assign mode_all = {s_r.mode1, s_r.mode0}; // see RL11 see RL12

	// Read multiplexer, evaluated in the setup cycle so that read data can come from a flop.
	always_comb begin
		rd_byte = can_mbx_pkg::RST_BYTE;
		rd_ok = 1'b1;
		case (region)
			can_mbx_pkg::RG_CFG: begin
				rd_byte = s_r.cfg[sel_a[1:0]] & can_mbx_pkg::CFG_KEEP_MASK; // see RL7 see RL8
			end
			can_mbx_pkg::RG_MODE0: begin
				rd_byte = s_r.mode0; // see RL11
			end
			can_mbx_pkg::RG_MODE1: begin
				rd_byte = {4'h0, s_r.mode1}; // see RL12
			end
			can_mbx_pkg::RG_STAT: begin
				rd_byte = {5'h00, INIT_MODE, TX_MAILBOX_EMPTY};
			end
			can_mbx_pkg::RG_MBX: begin
				if (sel_a[1:0] == can_mbx_pkg::MBX_RX) begin
					if (sel_b == 4'(can_mbx_pkg::SLOT_LEN)) begin
						rd_byte = s_r.rx_len & can_mbx_pkg::LEN_KEEP_MASK; // see RL2
					end else begin
						rd_byte = s_r.rx_pay[3'(sel_b - 4'h1)];
					end
				end else if (sel_a[1:0] < 2'(can_mbx_pkg::NUM_TX)) begin
					if (sel_b == 4'(can_mbx_pkg::SLOT_LEN)) begin
						rd_byte = s_r.tx_len[sel_a[0]] & can_mbx_pkg::LEN_KEEP_MASK; // see RL2
					end else begin
						rd_byte = s_r.tx_pay[sel_a[0]][3'(sel_b - 4'h1)]; // see RL4
					end
				end else begin
					rd_ok = 1'b0;
				end
			end
			can_mbx_pkg::RG_FILT: begin
				if (sel_a < 3'(can_mbx_pkg::NUM_FILTERS)) begin
					rd_byte = s_r.fbytes[sel_a][sel_b[2:0]]; // see RL15
				end else begin
					rd_ok = 1'b0;
				end
			end
			default: begin
				rd_ok = 1'b0;
			end
		endcase
	end

	// Next-state logic: read capture, software writes with their locks, receive loads.
	// Blocked writes finish normally without an error, so software sees the lock only by
	// reading back; an error answer is kept for addresses that hold nothing.
	always_comb begin
		s_nxt = s_r;
		if (setup) begin
			s_nxt.rdata = {24'h000000, rd_byte};
			s_nxt.err = ~rd_ok;
		end
		if (wr_take) begin
			case (region)
				can_mbx_pkg::RG_CFG: begin
					// Scale and activate changes are meant for initialization mode only,
					// but the hardware does not police that; software keeps to it.
					if (sel_a < 3'(can_mbx_pkg::NUM_PAIRS)) begin
						s_nxt.cfg[sel_a[1:0]] = wbyte & can_mbx_pkg::CFG_KEEP_MASK; // see RL7 see RL8 see RL6
					end
				end
				can_mbx_pkg::RG_MODE0: begin
					s_nxt.mode0 = wbyte; // see RL11
				end
				can_mbx_pkg::RG_MODE1: begin
					s_nxt.mode1 = wbyte[3:0] & can_mbx_pkg::MODE1_KEEP_MASK; // see RL12
				end
				can_mbx_pkg::RG_MBX: begin
					// The receive mailbox has no software write path at all.
					if (sel_a[1:0] < 2'(can_mbx_pkg::NUM_TX)) begin // see RL17
						if (TX_MAILBOX_EMPTY[sel_a[0]]) begin // see RL16
							if (sel_b == 4'(can_mbx_pkg::SLOT_LEN)) begin
								s_nxt.tx_len[sel_a[0]] = wbyte & can_mbx_pkg::LEN_KEEP_MASK; // see RL1 see RL2 see RL3
							end else begin
								s_nxt.tx_pay[sel_a[0]][3'(sel_b - 4'h1)] = wbyte; // see RL5 see RL4
							end
						end
					end
				end
				can_mbx_pkg::RG_FILT: begin
					// An active filter keeps its bytes so that matching never sees a half update.
					if (sel_a < 3'(can_mbx_pkg::NUM_FILTERS)) begin
						if (!act_of(s_r.cfg, int'(sel_a))) begin // see RL18 see RL10
							s_nxt.fbytes[sel_a][sel_b[2:0]] = wbyte; // see RL13 see RL14 see RL15
						end
					end
				end
				default: begin
					s_nxt.err = s_r.err;
				end
			endcase
		end
		// The protocol engine fills the receive mailbox: slot zero is the length code.
		if (RX_WR) begin
			if (RX_SLOT == 4'(can_mbx_pkg::SLOT_LEN)) begin
				s_nxt.rx_len = RX_DATA & can_mbx_pkg::LEN_KEEP_MASK; // see RL3
			end else if (RX_SLOT <= 4'(can_mbx_pkg::SLOT_LAST)) begin
				s_nxt.rx_pay[3'(RX_SLOT - 4'h1)] = RX_DATA; // see RL4
			end
		end
	end

	// All state registers; length code and payload come up cleared although software
	// must not rely on any value there before it writes them.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			s_r.cfg <= '0;
			s_r.mode0 <= can_mbx_pkg::RST_BYTE;
			s_r.mode1 <= 4'h0;
			s_r.tx_len <= '0;
			s_r.tx_pay <= '0;
			s_r.rx_len <= can_mbx_pkg::RST_BYTE;
			s_r.rx_pay <= '0;
			s_r.fbytes <= '0;
			s_r.rdata <= can_mbx_pkg::RST_WORD;
			s_r.err <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Bus answer: data and error were captured in the setup cycle.
	assign PRDATA = s_r.rdata;
	assign PSLVERR = s_r.err & PSEL & PENABLE;

	// Per-filter configuration towards the matching datapath.
	genvar gf;
	generate
		for (gf = 0; gf < can_mbx_pkg::NUM_FILTERS; gf++) begin : g_filt
			assign FILTER_ACTIVE[gf] = act_of(s_r.cfg, gf); // see RL9
			assign FILTER_SCALE[2*gf +: 2] = scale_of(s_r.cfg, gf); // see RL7 see RL8
			assign FILTER_MODE_HIGH[gf] = mode_all[2*gf+1]; // see RL11 see RL12
			assign FILTER_MODE_LOW[gf] = mode_all[2*gf]; // see RL11 see RL12
			assign FILTER_BYTES[64*gf +: 64] = s_r.fbytes[gf]; // see RL15
		end
	endgenerate

	// Transmit mailbox contents towards the protocol engine.
	genvar gt;
	generate
		for (gt = 0; gt < can_mbx_pkg::NUM_TX; gt++) begin : g_tx
			assign TX_LENGTH[4*gt +: 4] = s_r.tx_len[gt][3:0]; // see RL3
			assign TX_PAYLOAD[64*gt +: 64] = s_r.tx_pay[gt]; // see RL4
		end
	endgenerate
endmodule

// *** design/can_mbx_pkg.sv ***
// Constants, types and register map of the CAN mailbox payload and filter configuration block.
// Behaviour
// RL1: Length code writes to a transmit mailbox are blocked while it is not empty.
// RL2: Length code bits 6:4 always read zero; software writes zero to bit 7.
// RL3: Length code bits 3:0 give payload byte count sent or requested.
// RL4: Each mailbox holds eight byte-wide payload registers, zero to eight bytes used.
// RL5: Payload byte writes are blocked while the mailbox is not empty.
// RL6: Software changes filter scale and activation only in initialization mode.
// RL7: First config register: filter 1 scale 6:5, activate 4; filter 0 scale 2:1, activate 0.
// RL8: Second and third config registers hold filters 3,2 and 5,4 the same way.
// RL9: Activate bit one makes the filter take part in acceptance; zero disables it.
// RL10: Software clears activate before changing any of that filter's byte registers.
// RL11: First mode register holds high and low mode bits of filters 0 to 3; 1 is list.
// RL12: Second mode register holds filters 5 and 4 in bits 3:0; bits 7:4 read zero.
// RL13: Identifier byte bit zero expects dominant, one expects recessive.
// RL14: Mask byte bit zero ignores that bit; one requires equality with identifier.
// RL15: Each filter has eight byte registers; mask bytes share the identifier bit mapping.
// RL16: A transmit mailbox is empty and writable only while its empty flag is set.
// RL17: The receive mailbox is never writable by software.
// RL18: Filter byte writes are ignored while that filter's activate bit is set.
package can_mbx_pkg;
	localparam int NUM_FILTERS = 6;
	localparam int NUM_PAIRS = 3;
	localparam int NUM_TX = 2;
	localparam int NUM_BYTES = 8;
	localparam int SLOT_LEN = 0;
	localparam int SLOT_LAST = 8;
	// Byte addresses on the APB side.
	localparam logic [11:0] ADDR_CFG_PAIR_0_1 = 12'h000;
	localparam logic [11:0] ADDR_CFG_PAIR_2_3 = 12'h004;
	localparam logic [11:0] ADDR_CFG_PAIR_4_5 = 12'h008;
	localparam logic [11:0] ADDR_MODE_0_TO_3 = 12'h00C;
	localparam logic [11:0] ADDR_MODE_4_5 = 12'h010;
	localparam logic [11:0] ADDR_STATUS = 12'h014;
	localparam logic [11:0] ADDR_GLOBAL_END = 12'h018;
	localparam logic [11:0] ADDR_MBX_BASE = 12'h040;
	localparam logic [11:0] ADDR_MBX_END = 12'h100;
	localparam logic [11:0] ADDR_FILT_BASE = 12'h100;
	localparam logic [11:0] ADDR_FILT_END = 12'h1C0;
	localparam logic [1:0] MBX_RX = 2'h2;
	// Field layouts.
	localparam logic [7:0] LEN_KEEP_MASK = 8'h8F;
	localparam logic [7:0] CFG_KEEP_MASK = 8'h77;
	localparam logic [3:0] MODE1_KEEP_MASK = 4'hF;
	localparam int CFG_ACT_LO = 0;
	localparam int CFG_SCALE_LO = 1;
	localparam int CFG_ACT_HI = 4;
	localparam int CFG_SCALE_HI = 5;
	localparam int SCALE_W = 2;
	localparam int STAT_INIT_BIT = 2;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	typedef enum logic [2:0] {
		RG_NONE = 3'b000,
		RG_CFG = 3'b001,
		RG_MODE0 = 3'b010,
		RG_MODE1 = 3'b011,
		RG_STAT = 3'b100,
		RG_MBX = 3'b101,
		RG_FILT = 3'b110
	} region_t;

	typedef logic [7:0] byte_t;
	typedef byte_t [NUM_BYTES-1:0] bytes8_t;
endpackage

// *** design/apb_decode.sv ***
// APB handshake and address decode shared by the register file.
module apb_decode (
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	output logic setup,
	output logic wr_take,
	output logic pready,
	output can_mbx_pkg::region_t region,
	output logic [2:0] sel_a,
	output logic [3:0] sel_b
);
	// The slave never stalls: read data is prepared in the setup cycle.
	assign setup = psel & ~penable;
	assign wr_take = psel & penable & pwrite;
	assign pready = 1'b1;

	// Address decode; misaligned or unmapped addresses fall to RG_NONE.
	always_comb begin
		region = can_mbx_pkg::RG_NONE;
		sel_a = 3'h0;
		sel_b = 4'h0;
		if (paddr[1:0] != 2'h0) begin
			region = can_mbx_pkg::RG_NONE;
		end else if (paddr < can_mbx_pkg::ADDR_GLOBAL_END) begin
			sel_a = paddr[4:2];
			case (paddr)
				can_mbx_pkg::ADDR_MODE_0_TO_3: region = can_mbx_pkg::RG_MODE0;
				can_mbx_pkg::ADDR_MODE_4_5: region = can_mbx_pkg::RG_MODE1;
				can_mbx_pkg::ADDR_STATUS: region = can_mbx_pkg::RG_STAT;
				default: region = can_mbx_pkg::RG_CFG;
			endcase
		end else if (paddr >= can_mbx_pkg::ADDR_MBX_BASE && paddr < can_mbx_pkg::ADDR_MBX_END) begin
			sel_a = {1'b0, paddr[7:6] - 2'h1};
			sel_b = paddr[5:2];
			if (sel_b <= 4'(can_mbx_pkg::SLOT_LAST)) begin
				region = can_mbx_pkg::RG_MBX;
			end
		end else if (paddr >= can_mbx_pkg::ADDR_FILT_BASE && paddr < can_mbx_pkg::ADDR_FILT_END) begin
			sel_a = paddr[7:5];
			sel_b = {1'b0, paddr[4:2]};
			region = can_mbx_pkg::RG_FILT;
		end
	end
endmodule

// *** test/can_mbx_regs_checker.sv ***
// Concurrent checks on the ports of the mailbox and filter register block.
module can_mbx_regs_checker (
	input wire logic CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic [1:0] TX_MAILBOX_EMPTY,
	input wire logic [5:0] FILTER_ACTIVE,
	input wire logic [11:0] FILTER_SCALE,
	input wire logic [5:0] FILTER_MODE_HIGH,
	input wire logic [5:0] FILTER_MODE_LOW,
	input wire logic [383:0] FILTER_BYTES,
	input wire logic [7:0] TX_LENGTH,
	input wire logic [127:0] TX_PAYLOAD
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	logic wr;
	logic [7:0] pw_r;
	// Write data of the last cycle, so field checks read short one cycle after the access edge.
	assign wr = PSEL && PENABLE && PWRITE;
	always_ff @(posedge CLK) begin
		pw_r <= PWDATA[7:0];
	end
	// A busy mailbox ignores software writes to its length code and payload, an empty one takes length code writes; length reads show bits 6:4 as zero.
	len_lock_a: assert property (wr && PADDR == 12'h040 && !TX_MAILBOX_EMPTY[0] |=> $stable(TX_LENGTH[3:0]))
		else $error("length code changed while mailbox busy");
	len_take_a: assert property (wr && PADDR == 12'h040 && TX_MAILBOX_EMPTY[0] |=> TX_LENGTH[3:0] == pw_r[3:0])
		else $error("length code not taken from write");
	pay_lock_a: assert property (wr && PADDR == 12'h0A0 && !TX_MAILBOX_EMPTY[1] |=> $stable(TX_PAYLOAD[127:120]))
		else $error("payload changed while mailbox busy");
	len_read_a: assert property (PSEL && PENABLE && !PWRITE && PADDR == 12'h040 |-> PRDATA[6:4] == 3'h0 && PRDATA[3:0] == TX_LENGTH[3:0])
		else $error("length code read shows reserved bits");
	// Field positions of the configuration and mode registers, and the byte lock of an active filter.
	cfg_low_a: assert property (wr && PADDR == 12'h000 |=> FILTER_ACTIVE[1:0] == {pw_r[4], pw_r[0]} && FILTER_SCALE[3:0] == {pw_r[6:5], pw_r[2:1]})
		else $error("first config register fields misplaced");
	cfg_high_a: assert property (wr && PADDR == 12'h008 |=> FILTER_ACTIVE[5:4] == {pw_r[4], pw_r[0]} && FILTER_SCALE[11:8] == {pw_r[6:5], pw_r[2:1]})
		else $error("third config register fields misplaced");
	mode_low_a: assert property (wr && PADDR == 12'h00C |=> FILTER_MODE_HIGH[3:0] == {pw_r[7], pw_r[5], pw_r[3], pw_r[1]})
		else $error("first mode register high bits misplaced");
	mode_high_a: assert property (wr && PADDR == 12'h010 |=> FILTER_MODE_HIGH[5:4] == {pw_r[3], pw_r[1]} && FILTER_MODE_LOW[5:4] == {pw_r[2], pw_r[0]})
		else $error("second mode register bits misplaced");
	filt_lock_a: assert property (wr && PADDR == 12'h120 && FILTER_ACTIVE[1] |=> $stable(FILTER_BYTES[71:64]))
		else $error("active filter byte changed");
	cover property (wr && PADDR == 12'h040 && !TX_MAILBOX_EMPTY[0]);
	cover property (wr && PADDR == 12'h120 && FILTER_ACTIVE[1]);
	cover property (wr && PADDR == 12'h008);
endmodule

bind can_mbx_regs can_mbx_regs_checker i_chk (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .TX_MAILBOX_EMPTY(TX_MAILBOX_EMPTY), .FILTER_ACTIVE(FILTER_ACTIVE),
	.FILTER_SCALE(FILTER_SCALE), .FILTER_MODE_HIGH(FILTER_MODE_HIGH), .FILTER_MODE_LOW(FILTER_MODE_LOW),
	.FILTER_BYTES(FILTER_BYTES), .TX_LENGTH(TX_LENGTH), .TX_PAYLOAD(TX_PAYLOAD));

// *** test/can_engine_model.sv ***
// Behavioural protocol engine facing the mailbox and filter register block.
module can_engine_model (
	input wire logic CLK,
	output logic [1:0] TX_MAILBOX_EMPTY,
	output logic INIT_MODE,
	output logic RX_WR,
	output logic [3:0] RX_SLOT,
	output logic [7:0] RX_DATA
);
	timeunit 1ns;
	timeprecision 1ps;
	// Mailboxes start empty and the controller stays in initialization mode during set-up.
	// The receive strobe stays idle until rx_load stores a byte of a received frame.
	initial begin
		TX_MAILBOX_EMPTY = 2'h3;
		INIT_MODE = 1'b1;
		RX_WR = 1'b0;
		RX_SLOT = 4'h0;
		RX_DATA = 8'h00;
	end
	// Queues or frees a mailbox; a queued mailbox is no longer empty and so locked.
	task automatic set_empty(input int m, input logic v);
		@(posedge CLK);
		TX_MAILBOX_EMPTY[m] <= v;
	endtask
	// Stores one byte of a received frame: slot zero is the length code, slots one to eight the payload.
	task automatic rx_load(input logic [3:0] slot, input logic [7:0] d);
		@(posedge CLK);
		RX_WR <= 1'b1;
		RX_SLOT <= slot;
		RX_DATA <= d;
		@(posedge CLK);
		RX_WR <= 1'b0;
	endtask
endmodule

// *** test/can_mailbox_payload_and_filter_config_tb.sv ***
// Self-checking bench for the mailbox and filter register block.
module can_mailbox_payload_and_filter_config_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, INIT_MODE, RX_WR, err;
	logic [11:0] PADDR, FILTER_SCALE;
	logic [31:0] PWDATA, PRDATA, rd;
	logic [1:0] TX_MAILBOX_EMPTY;
	logic [3:0] RX_SLOT;
	logic [7:0] RX_DATA, TX_LENGTH;
	logic [5:0] FILTER_ACTIVE, FILTER_MODE_HIGH, FILTER_MODE_LOW;
	logic [383:0] FILTER_BYTES;
	logic [127:0] TX_PAYLOAD;
	int fail_count = 0;
	int checked = 0;
	int cycles = 0;
	can_mbx_regs i_dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TX_MAILBOX_EMPTY(TX_MAILBOX_EMPTY),
		.INIT_MODE(INIT_MODE), .RX_WR(RX_WR), .RX_SLOT(RX_SLOT), .RX_DATA(RX_DATA), .FILTER_ACTIVE(FILTER_ACTIVE),
		.FILTER_SCALE(FILTER_SCALE), .FILTER_MODE_HIGH(FILTER_MODE_HIGH), .FILTER_MODE_LOW(FILTER_MODE_LOW),
		.FILTER_BYTES(FILTER_BYTES), .TX_LENGTH(TX_LENGTH), .TX_PAYLOAD(TX_PAYLOAD));
	can_engine_model i_eng (.CLK(CLK), .TX_MAILBOX_EMPTY(TX_MAILBOX_EMPTY), .INIT_MODE(INIT_MODE), .RX_WR(RX_WR),
		.RX_SLOT(RX_SLOT), .RX_DATA(RX_DATA));
	// Free-running 50 MHz clock.
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end
	task automatic give_verdict();
		if (fail_count == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One APB transfer; an idle cycle follows so no signal is driven twice in one time step.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		@(posedge CLK);
		// Only the bench timeout ends a wait for the answer.
		while (PREADY !== 1'b1) begin
			@(posedge CLK);
		end
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, err);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string name);
		apb(1'b0, a, 32'h0, rd, err);
		chk(name, rd, exp);
	endtask
	// A hang is cut short well beyond the few hundred cycles the sequence needs.
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			give_verdict();
		end
	end
	initial begin
		RST = 1'b1;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 12'h000;
		PWDATA = 32'h0;
		repeat (8) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		for (int i = 0; i < 5; i++) rdchk(12'(4 * i), 32'h0, "cfg reset");
		wr(12'h040, 32'h0000_007A);
		rdchk(12'h040, 32'h0000_000A, "length read");
		chk("length out", {28'h0, TX_LENGTH[3:0]}, 32'h0000_000A);
		i_eng.set_empty(0, 1'b0);
		wr(12'h040, 32'h0000_0005);
		rdchk(12'h040, 32'h0000_000A, "length locked");
		for (int b = 0; b < 8; b++) wr(12'h084 + 12'(4 * b), 32'h10 + 32'(b));
		for (int b = 0; b < 8; b++) rdchk(12'h084 + 12'(4 * b), 32'h10 + 32'(b), "payload");
		i_eng.set_empty(1, 1'b0);
		wr(12'h0A0, 32'h0000_00EE);
		rdchk(12'h0A0, 32'h0000_0017, "payload locked");
		chk("payload out", {24'h0, TX_PAYLOAD[127:120]}, 32'h0000_0017);
		rdchk(12'h014, 32'h0000_0004, "status");
		// Value DA puts different patterns in each field, so swapped fields show.
		for (int p = 0; p < 3; p++) begin
			wr(12'(4 * p), 32'h0000_00DA);
			rdchk(12'(4 * p), 32'h0000_0052, "cfg fields");
			chk("active", {30'h0, FILTER_ACTIVE[2 * p +: 2]}, 32'h2);
			chk("scale", {28'h0, FILTER_SCALE[4 * p +: 4]}, 32'h9);
		end
		wr(12'h00C, 32'h0000_0096);
		rdchk(12'h00C, 32'h0000_0096, "mode0");
		chk("mode0 out", {24'h0, FILTER_MODE_HIGH[3:0], FILTER_MODE_LOW[3:0]}, 32'h96);
		wr(12'h010, 32'h0000_00FA);
		rdchk(12'h010, 32'h0000_000A, "mode1");
		chk("mode1 out", {28'h0, FILTER_MODE_HIGH[5:4], FILTER_MODE_LOW[5:4]}, 32'hC);
		for (int b = 0; b < 8; b++) begin
			wr(12'h100 + 12'(4 * b), 32'hA0 + 32'(b));
			rdchk(12'h100 + 12'(4 * b), 32'hA0 + 32'(b), "filter byte");
			chk("filter out", {24'h0, FILTER_BYTES[8 * b +: 8]}, 32'hA0 + 32'(b));
		end
		wr(12'h120, 32'h0000_003C);
		rdchk(12'h120, 32'h0, "filter locked");
		wr(12'h000, 32'h0);
		wr(12'h120, 32'h0000_003C);
		rdchk(12'h120, 32'h0000_003C, "filter unlocked");
		// The engine fills the receive mailbox; software writes there must leave it unchanged.
		i_eng.rx_load(4'h0, 8'h7C);
		i_eng.rx_load(4'h1, 8'h5A);
		wr(12'h0C0, 32'h0000_0003);
		rdchk(12'h0C0, 32'h0000_000C, "rx length");
		wr(12'h0C4, 32'h0000_00FF);
		rdchk(12'h0C4, 32'h0000_005A, "rx payload");
		apb(1'b0, 12'h018, 32'h0, rd, err);
		chk("unmapped err", {31'h0, err}, 32'h1);
		chk("unmapped data", rd, 32'h0);
		apb(1'b0, 12'h002, 32'h0, rd, err);
		chk("misaligned err", {31'h0, err}, 32'h1);
		give_verdict();
	end
endmodule
